/* src/nfc_defines.vh */
//------------------------------------------------------------
// nand cache program / cache read host constants
//------------------------------------------------------------
// Functional notes
// - load page, confirm with cache code 15h
// - ready/busy tracking: last page uses 10h
// - last page 15h: poll bit 5 first
// - all pages in one block and plane
// - cache read confirmed with 31h code
// - cache read starts at column zero
// - exit cache read with 34h anytime; the host accepts the exit only while streaming (S_STRM)
// - reading to array end needs exit command
// - no column change during cache read
// - cache read limited to one block
// - wait 10us after power-up
// - data load: 80h, five addresses, data
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH
// command codes
`define NFC_CMD_READ     8'h00
`define NFC_CMD_PROG     8'h10
`define NFC_CMD_CPROG    8'h15
`define NFC_CMD_CREAD    8'h31
`define NFC_CMD_CEXIT    8'h34
`define NFC_CMD_STATUS   8'h70
`define NFC_CMD_SDIN     8'h80
// device status bits
`define NFC_SR_ARRAY     5
`define NFC_SR_CACHE     6
// own register byte offsets
`define NFC_REG_CMD      8'h00
`define NFC_REG_COL      8'h04
`define NFC_REG_ROW      8'h08
`define NFC_REG_LEN      8'h0c
`define NFC_REG_DATA     8'h10
`define NFC_REG_STAT     8'h14
// command register fields
`define NFC_OP_NONE      3'h0
`define NFC_OP_PROG      3'h1
`define NFC_OP_CREAD     3'h2
`define NFC_OP_CEXIT     3'h3
`define NFC_OP_STAT      3'h4
`define NFC_F_LAST10     3
`define NFC_F_LAST15     4
// timing, in ns and us, and derived cycle counts
`define NFC_CLK_MHZ      100
`define NFC_T_PWR_US     10
`define NFC_T_WP_NS      15
`define NFC_T_WC_NS      30
`define NFC_T_ADL_NS     100
`define NFC_T_WB_NS      100
`define NFC_PWR_CYC      (`NFC_T_PWR_US * `NFC_CLK_MHZ)
`define NFC_STB_LOW      ((`NFC_T_WP_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_STB_TOT      ((`NFC_T_WC_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_ADL_CYC      ((`NFC_T_ADL_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_WB_CYC       ((`NFC_T_WB_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_ADDR_CYC     3'h5
`endif

/* src/nfc_cache_host.v */
`timescale 1ns/1ns
`default_nettype none
`include "nfc_defines.vh"
module nfc_cache_host #(
   parameter PAGE_BITS = 6,
   parameter ROW_W     = 24
) (
   input  wire        ref_clk_in,
   input  wire        arst_n_in,
   input  wire [7:0]  addr_in,
   input  wire [31:0] wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [31:0] rdata_out,
   output reg         ce_n_out,
   output reg         cle_out,
   output reg         ale_out,
   output reg         we_n_out,
   output reg         re_n_out,
   output reg         wp_n_out,
   output reg  [7:0]  io_out,
   output reg         io_oe_out,
   input  wire [7:0]  io_in,
   input  wire        rb_in
);
   //------------------------------------------------------------
   // states, cycle kinds and poll conditions
   //------------------------------------------------------------
   localparam S_PWR  = 4'h0;
   localparam S_IDLE = 4'h1;
   localparam S_CMD1 = 4'h2;
   localparam S_ADDR = 4'h3;
   localparam S_ADL  = 4'h4;
   localparam S_DATA = 4'h5;
   localparam S_PCHK = 4'h6;
   localparam S_PRD  = 4'h7;
   localparam S_CONF = 4'h8;
   localparam S_TWB  = 4'h9;
   localparam S_RB   = 4'ha;
   localparam S_STRM = 4'hb;
   localparam K_CMD  = 2'h0;
   localparam K_ADR  = 2'h1;
   localparam K_DIN  = 2'h2;
   localparam K_DOUT = 2'h3;
   localparam P_ONE  = 2'h0;   // single status read
   localparam P_B6   = 2'h1;   // wait cache ready
   localparam P_B5   = 2'h2;   // wait array idle

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   reg [3:0]       st_q;        // sequencer state
   reg [2:0]       op_q;        // running operation
   reg [4:0]       flg_q;       // flags of the running operation
   reg [1:0]       psel_q;      // status poll condition
   reg             ph2_q;       // final-page bit 5 poll under way
   reg [2:0]       ai_q;        // address cycle index
   reg [11:0]      bc_q;        // data bytes still to load
   reg [10:0]      wt_q;        // wait counter
   reg             err_q;       // sticky refusal flag
   reg             cps_q;       // cache program sequence open
   reg [ROW_W-1:0] blk_q;       // row of first page in sequence
   reg [7:0]       sr_q;        // last device status read
   reg [7:0]       dout_q;      // last byte streamed out
   reg [15:0]      col_q;       // column address
   reg [ROW_W-1:0] row_q;       // row address
   reg [11:0]      len_q;       // bytes per page load
   reg             req_q;       // cycle request to pin engine
   reg [1:0]       rk_q;        // requested cycle kind
   reg [7:0]       rbyte_q;     // requested byte
   reg             e_act_q;     // pin engine busy
   reg             e_done_q;    // pin engine finished, one pulse
   reg [1:0]       e_kind_q;    // kind under way
   reg [1:0]       e_cnt_q;     // cycle within strobe

   // engine free and no request or finish in flight
   wire e_idle = !e_act_q && !e_done_q && !req_q;
   wire [ROW_W-1:0] new_row = wdata_in[ROW_W-1:0];

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   // register select, used by several processes
   function sel;
      input [7:0] a;
      input [7:0] off;
      begin
         sel = (a == off);
      end
   endfunction

   // address byte for cycle index, column first then row
   function [7:0] adr_byte;
      input [2:0]       i;
      input [15:0]      c;
      input [ROW_W-1:0] r;
      begin
         if (i == 3'h0) begin
            adr_byte = c[7:0];
         end else if (i == 3'h1) begin
            adr_byte = c[15:8];
         end else if (i == 3'h2) begin
            adr_byte = r[7:0];
         end else if (i == 3'h3) begin
            adr_byte = r[15:8];
         end else begin
            adr_byte = r[23:16];
         end
      end
   endfunction

   // block part of a row; it holds the plane select bit as well
   function same_blk;
      input [ROW_W-1:0] a;
      input [ROW_W-1:0] b;
      begin
         same_blk = (a[ROW_W-1:PAGE_BITS] == b[ROW_W-1:PAGE_BITS]);
      end
   endfunction

   //------------------------------------------------------------
   // address registers
   //------------------------------------------------------------
   // column, row and length stay put while an operation runs
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         col_q <= 16'h0000;
         row_q <= {ROW_W{1'b0}};
         len_q <= 12'h000;
      end else if (wr_in && st_q == S_IDLE) begin
         if (sel(addr_in, `NFC_REG_COL)) begin
            col_q <= wdata_in[15:0];
         end else if (sel(addr_in, `NFC_REG_ROW)) begin
            row_q <= new_row;
         end else if (sel(addr_in, `NFC_REG_LEN)) begin
            len_q <= wdata_in[11:0];
         end
      end
   end

   //------------------------------------------------------------
   // read port, data one cycle after the strobe
   //------------------------------------------------------------
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_out <= 32'h0000_0000;
      end else if (rd_in) begin
         if (sel(addr_in, `NFC_REG_COL)) begin
            rdata_out <= {16'h0000, col_q};
         end else if (sel(addr_in, `NFC_REG_ROW)) begin
            rdata_out <= {{(32-ROW_W){1'b0}}, row_q};
         end else if (sel(addr_in, `NFC_REG_LEN)) begin
            rdata_out <= {20'h00000, len_q};
         end else if (sel(addr_in, `NFC_REG_DATA)) begin
            rdata_out <= {24'h000000, dout_q};
         end else if (sel(addr_in, `NFC_REG_STAT)) begin
            rdata_out <= {16'h0000, sr_q, 1'b0, (st_q == S_STRM), cps_q,
                          (st_q != S_PWR), err_q,
                          (st_q == S_STRM && e_idle && rb_in),
                          (st_q == S_DATA && e_idle),
                          (st_q != S_IDLE)};
         end else begin
            // unmapped and write-only offsets read as zero
            rdata_out <= 32'h0000_0000;
         end
      end
   end

   //------------------------------------------------------------
   // pin engine: one command, address or data cycle per request
   //------------------------------------------------------------
   // strobe low for the pulse width, then high until the cycle time;
   // latches drop a cycle after the strobe rises for hold time
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         e_act_q   <= 1'b0;
         e_done_q  <= 1'b0;
         e_kind_q  <= K_CMD;
         e_cnt_q   <= 2'h0;
         cle_out   <= 1'b0;
         ale_out   <= 1'b0;
         we_n_out  <= 1'b1;
         re_n_out  <= 1'b1;
         io_out    <= 8'h00;
         io_oe_out <= 1'b0;
         dout_q    <= 8'h00;
      end else begin
         e_done_q <= 1'b0;
         if (!e_act_q && req_q) begin
            e_act_q  <= 1'b1;
            e_kind_q <= rk_q;
            e_cnt_q  <= 2'h0;
            cle_out  <= (rk_q == K_CMD);
            ale_out  <= (rk_q == K_ADR);
            if (rk_q == K_DOUT) begin
               re_n_out <= 1'b0;
            end else begin
               we_n_out  <= 1'b0;
               io_out    <= rbyte_q;
               io_oe_out <= 1'b1;
            end
         end else if (e_act_q) begin
            e_cnt_q <= e_cnt_q + 2'h1;
            if (e_cnt_q == `NFC_STB_LOW - 1) begin
               we_n_out <= 1'b1;
               re_n_out <= 1'b1;
               if (e_kind_q == K_DOUT) begin
                  dout_q <= io_in;
               end
            end
            if (e_cnt_q == `NFC_STB_TOT - 1) begin
               e_act_q   <= 1'b0;
               e_done_q  <= 1'b1;
               cle_out   <= 1'b0;
               ale_out   <= 1'b0;
               io_oe_out <= 1'b0;
            end
         end
      end
   end

   //------------------------------------------------------------
   // operation sequencer
   //------------------------------------------------------------
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q     <= S_PWR;
         op_q     <= `NFC_OP_NONE;
         flg_q    <= 5'h00;
         psel_q   <= P_ONE;
         ph2_q    <= 1'b0;
         ai_q     <= 3'h0;
         bc_q     <= 12'h000;
         wt_q     <= 11'h000;
         err_q    <= 1'b0;
         cps_q    <= 1'b0;
         blk_q    <= {ROW_W{1'b0}};
         sr_q     <= 8'h00;
         req_q    <= 1'b0;
         rk_q     <= K_CMD;
         rbyte_q  <= 8'h00;
         ce_n_out <= 1'b1;
         wp_n_out <= 1'b0;
      end else begin
         req_q <= 1'b0;
         // software clears the error flag by writing status
         if (wr_in && sel(addr_in, `NFC_REG_STAT)) begin
            err_q <= 1'b0;
         end
         ce_n_out <= (st_q == S_PWR || st_q == S_IDLE);
         case (st_q)
            S_PWR: begin
               wt_q <= wt_q + 11'h001;
               if (wt_q == `NFC_PWR_CYC - 1) begin
                  wp_n_out <= 1'b1;
                  st_q     <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (wr_in && sel(addr_in, `NFC_REG_CMD)) begin
                  op_q  <= wdata_in[2:0];
                  flg_q <= wdata_in[4:0];
                  ph2_q <= 1'b0;
                  ai_q  <= 3'h0;
                  if (wdata_in[2:0] == `NFC_OP_PROG) begin
                     if (cps_q && !same_blk(row_q, blk_q)) begin
                        err_q <= 1'b1;
                     end else begin
                        psel_q <= P_B6;
                        st_q   <= S_PCHK;
                     end
                  end else if (wdata_in[2:0] == `NFC_OP_CREAD) begin
                     st_q <= S_CMD1;
                  end else if (wdata_in[2:0] == `NFC_OP_STAT) begin
                     psel_q <= P_ONE;
                     st_q   <= S_PCHK;
                  end else begin
                     err_q <= 1'b1;
                  end
               end else if (wr_in && sel(addr_in, `NFC_REG_DATA)) begin
                  err_q <= 1'b1;
               end
            end
            S_CMD1: begin
               if (e_idle) begin
                  req_q <= 1'b1;
                  rk_q  <= K_CMD;
                  if (op_q == `NFC_OP_PROG) begin
                     rbyte_q <= `NFC_CMD_SDIN;
                  end else if (op_q == `NFC_OP_CREAD) begin
                     rbyte_q <= `NFC_CMD_READ;
                  end else begin
                     rbyte_q <= `NFC_CMD_CEXIT;
                  end
               end
               if (e_done_q) begin
                  wt_q <= 11'h000;
                  st_q <= (op_q == `NFC_OP_CEXIT) ? S_TWB : S_ADDR;
               end
            end
            S_ADDR: begin
               if (e_idle) begin
                  req_q <= 1'b1;
                  rk_q  <= K_ADR;
                  rbyte_q <= adr_byte(ai_q,
                     (op_q == `NFC_OP_CREAD) ? 16'h0000 : col_q, row_q);
               end
               if (e_done_q) begin
                  ai_q <= ai_q + 3'h1;
                  if (ai_q == `NFC_ADDR_CYC - 1) begin
                     wt_q <= 11'h000;
                     bc_q <= len_q;
                     st_q <= (op_q == `NFC_OP_PROG) ? S_ADL : S_CONF;
                  end
               end
            end
            // address to data loading gap
            S_ADL: begin
               wt_q <= wt_q + 11'h001;
               if (wt_q == `NFC_ADL_CYC - 1) begin
                  st_q <= S_DATA;
               end
            end
            // each data write up to the load length becomes one data cycle; a write
            // while the engine is busy is refused, not queued
            S_DATA: begin
               if (bc_q == 12'h000 && e_idle) begin
                  st_q <= S_CONF;
               end else if (wr_in && sel(addr_in, `NFC_REG_DATA)) begin
                  if (e_idle && bc_q != 12'h000) begin
                     req_q   <= 1'b1;
                     rk_q    <= K_DIN;
                     rbyte_q <= wdata_in[7:0];
                     bc_q    <= bc_q - 12'h001;
                  end else begin
                     err_q <= 1'b1;
                  end
               end
            end
            S_PCHK: begin
               if (e_idle) begin
                  req_q   <= 1'b1;
                  rk_q    <= K_CMD;
                  rbyte_q <= `NFC_CMD_STATUS;
               end
               if (e_done_q) begin
                  st_q <= S_PRD;
               end
            end
            // repeated reads stay in status mode
            S_PRD: begin
               if (e_idle) begin
                  req_q <= 1'b1;
                  rk_q  <= K_DOUT;
               end
               if (e_done_q) begin
                  sr_q <= dout_q;
                  if (psel_q == P_ONE) begin
                     st_q <= S_IDLE;
                  end else if (psel_q == P_B6 && dout_q[`NFC_SR_CACHE]) begin
                     st_q <= S_CMD1;
                  end else if (psel_q == P_B5 && dout_q[`NFC_SR_ARRAY]) begin
                     st_q <= S_IDLE;
                  end
               end
            end
            S_CONF: begin
               if (e_idle) begin
                  req_q <= 1'b1;
                  rk_q  <= K_CMD;
                  if (op_q == `NFC_OP_CREAD) begin
                     rbyte_q <= `NFC_CMD_CREAD;
                  end else if (flg_q[`NFC_F_LAST10]) begin
                     rbyte_q <= `NFC_CMD_PROG;
                  end else begin
                     rbyte_q <= `NFC_CMD_CPROG;
                  end
               end
               if (e_done_q) begin
                  wt_q <= 11'h000;
                  st_q <= S_TWB;
                  if (op_q == `NFC_OP_PROG) begin
                     if (!cps_q) begin
                        blk_q <= row_q;
                     end
                     cps_q <= !(flg_q[`NFC_F_LAST10] || flg_q[`NFC_F_LAST15]);
                  end
               end
            end
            // give the device time to pull ready/busy low
            S_TWB: begin
               wt_q <= wt_q + 11'h001;
               if (wt_q == `NFC_WB_CYC - 1) begin
                  st_q <= S_RB;
               end
            end
            S_RB: begin
               if (rb_in) begin
                  if (op_q == `NFC_OP_CREAD) begin
                     st_q <= S_STRM;
                  end else if (op_q == `NFC_OP_PROG && flg_q[`NFC_F_LAST15]
                               && !flg_q[`NFC_F_LAST10] && !ph2_q) begin
                     // poll array idle after last 15h
                     ph2_q  <= 1'b1;
                     psel_q <= P_B5;
                     st_q   <= S_PCHK;
                  end else begin
                     st_q <= S_IDLE;
                  end
               end
            end
            // stream while the next page is fetched
            S_STRM: begin
               if (wr_in && sel(addr_in, `NFC_REG_CMD)) begin
                  if (wdata_in[2:0] == `NFC_OP_CEXIT) begin
                     op_q <= `NFC_OP_CEXIT;
                     st_q <= S_CMD1;
                  end else begin
                     err_q <= 1'b1;
                  end
               end else if (rd_in && sel(addr_in, `NFC_REG_DATA)) begin
                  // read out only while ready/busy high
                  if (e_idle && rb_in) begin
                     req_q <= 1'b1;
                     rk_q  <= K_DOUT;
                  end else begin
                     err_q <= 1'b1;
                  end
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* testbench/nfc_cache_host_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module nfc_cache_host_assertions (
   input wire logic       ref_clk_in,
   input wire logic       arst_n_in,
   input wire logic       ce_n_out,
   input wire logic       cle_out,
   input wire logic       ale_out,
   input wire logic       we_n_out,
   input wire logic       re_n_out,
   input wire logic       wp_n_out,
   input wire logic [7:0] io_out,
   input wire logic       io_oe_out,
   input wire logic       rb_in
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   logic        we_q;                   // strobe one clock back
   logic [7:0]  cmd_q;                  // last latched command
   logic [2:0]  adr_q;                  // address bytes since that command
   logic [10:0] up_q;                   // clocks since reset release, saturating
   wire         lat = we_n_out & ~we_q; // flash latches on the rising strobe
   // helper state only looks at pins, so a design slip cannot hide in it
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         we_q  <= 1'b1;
         cmd_q <= 8'hff;
         adr_q <= 3'h0;
         up_q  <= 11'h000;
      end else begin
         we_q <= we_n_out;
         if (up_q != 11'h7ff) begin
            up_q <= up_q + 11'h001;
         end
         if (lat && cle_out) begin
            cmd_q <= io_out;
            adr_q <= 3'h0;
         end else if (lat && ale_out) begin
            adr_q <= adr_q + 3'h1;
         end
      end
   end
   property p_pwr; up_q < 11'd1000 |-> ce_n_out && !wp_n_out && we_n_out; endproperty
   a_pwr: assert property (p_pwr) else $error("flash touched in power wait");
   property p_sdin; lat && !cle_out && !ale_out && cmd_q == 8'h80 |-> adr_q == 3'h5; endproperty
   a_sdin: assert property (p_sdin) else $error("data before five addresses");
   property p_cfm;
      lat && cle_out && (io_out == 8'h10 || io_out == 8'h15) |-> cmd_q == 8'h80 && adr_q == 3'h5;
   endproperty
   a_cfm: assert property (p_cfm) else $error("confirm without load");
   property p_crd; lat && cle_out && io_out == 8'h31 |-> cmd_q == 8'h00 && adr_q == 3'h5; endproperty
   a_crd: assert property (p_crd) else $error("bad cache read start");
   property p_col; lat && ale_out && cmd_q == 8'h00 && adr_q < 3'h2 |-> io_out == 8'h00; endproperty
   a_col: assert property (p_col) else $error("cache read column not zero");
   property p_exit; lat && cle_out && cmd_q == 8'h31 |-> io_out == 8'h34; endproperty
   a_exit: assert property (p_exit) else $error("foreign command in stream");
   property p_lat; !re_n_out && cmd_q == 8'h31 |-> rb_in; endproperty
   a_lat: assert property (p_lat) else $error("read during latency");
   property p_bus; !re_n_out |-> !io_oe_out && we_n_out; endproperty
   a_bus: assert property (p_bus) else $error("host drives during read");
   c_cprog: cover property (lat && cle_out && io_out == 8'h15);
   c_cread: cover property (lat && cle_out && io_out == 8'h31);
   c_exit: cover property (lat && cle_out && io_out == 8'h34);
endmodule
bind nfc_cache_host nfc_cache_host_assertions chk_u (.ref_clk_in(ref_clk_in),
   .arst_n_in(arst_n_in), .ce_n_out(ce_n_out), .cle_out(cle_out), .ale_out(ale_out),
   .we_n_out(we_n_out), .re_n_out(re_n_out), .wp_n_out(wp_n_out), .io_out(io_out),
   .io_oe_out(io_oe_out), .rb_in(rb_in));
`default_nettype wire

/* testbench/nfc_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
module nfc_flash_model #(
   parameter int T_PROG = 60, // program time, shortened to clocks
   parameter int T_CBSY = 6,  // cache transfer time
   parameter int T_RD   = 40  // page fetch latency
) (
   input  wire logic       ref_clk_in,
   input  wire logic       ce_n_in,
   input  wire logic       cle_in,
   input  wire logic       ale_in,
   input  wire logic       we_n_in,
   input  wire logic       re_n_in,
   input  wire logic [7:0] dq_in,
   output wire logic [7:0] dq_out,
   output wire logic       rb_low_out
);
   logic       we_q = 1'b1;     // strobes one clock back
   logic       re_q = 1'b1;
   logic       sts_q = 1'b0;    // status mode
   logic       str_q = 1'b0;    // cache read stream
   logic [7:0] cmd_q = 8'hff;   // last command
   logic [7:0] conf_q = 8'h00;  // last program confirm
   logic [7:0] dat_q = 8'h00;   // next stream byte
   logic [7:0] last_q = 8'h00;  // last driven byte
   logic [7:0] adr_b [0:7];     // address bytes of last command
   logic [2:0] adr_q = 3'h0;
   int         prog_c = 0, cb_c = 0, rd_c = 0, loads = 0;
   wire        lat = we_n_in & ~we_q & ~ce_n_in;
   wire        oe = ~ce_n_in & ~re_n_in;
   wire  [7:0] sr = {1'b1, cb_c == 0, prog_c == 0 && rd_c == 0, 5'h00};
   // status mode holds; released bus shows inverse, never a stale match
   assign dq_out = oe ? (sts_q ? sr : dat_q) : ~last_q;
   // open drain pulled low while busy
   assign rb_low_out = cb_c != 0;
   always @(posedge ref_clk_in) begin
      we_q <= we_n_in;
      re_q <= re_n_in;
      if (oe) last_q <= dq_out;
      if (prog_c > 0) prog_c <= prog_c - 1;
      if (cb_c > 0) cb_c <= cb_c - 1;
      // next page fetched while the host streams
      if (rd_c > 0) rd_c <= (rd_c == 1 && str_q) ? T_RD : rd_c - 1;
      if (re_n_in && !re_q && str_q) dat_q <= dat_q + 8'h01;
      if (lat && ale_in) begin
         adr_b[adr_q] <= dq_in;
         adr_q <= adr_q + 3'h1;
      end
      if (lat && !cle_in && !ale_in) loads <= loads + 1;
      if (lat && cle_in) begin
         cmd_q <= dq_in;
         adr_q <= 3'h0;
         sts_q <= dq_in == 8'h70;
         case (dq_in)
            8'h80: loads <= 0;
            // plain confirm waits for pending work
            8'h10: begin prog_c <= prog_c + T_PROG; cb_c <= prog_c + T_PROG; conf_q <= dq_in; end
            8'h15: begin prog_c <= prog_c + T_PROG; cb_c <= prog_c + T_CBSY; conf_q <= dq_in; end
            8'h31: begin str_q <= 1'b1; cb_c <= T_RD; rd_c <= 2 * T_RD; dat_q <= 8'ha0; end
            // exit, quicker when a fetch runs
            8'h34: begin str_q <= 1'b0; rd_c <= 0; cb_c <= (rd_c != 0) ? 2 : 4; end
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        ref_clk_in = 1'b0;
   logic        arst_n_in  = 1'b0;
   logic        wr_in      = 1'b0;
   logic        rd_in      = 1'b0;
   logic [7:0]  addr_in    = 8'h00;
   logic [31:0] wdata_in   = 32'h0;
   logic [31:0] v;            // last register read
   wire  [31:0] rdata_out;
   wire  [7:0]  io_out, mdq, bus;
   wire         ce_n_out, cle_out, ale_out, we_n_out, re_n_out, wp_n_out, io_oe_out, rb_low;
   int          bad_count = 0, samples_checked = 0, cyc = 0;
   assign bus = io_oe_out ? io_out : mdq;  // resolved data bus
   always #5 ref_clk_in = ~ref_clk_in;
   nfc_cache_host dut_u (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .ce_n_out(ce_n_out), .cle_out(cle_out), .ale_out(ale_out), .we_n_out(we_n_out),
      .re_n_out(re_n_out), .wp_n_out(wp_n_out), .io_out(io_out), .io_oe_out(io_oe_out),
      .io_in(bus), .rb_in(~rb_low));
   nfc_flash_model mdl_u (.ref_clk_in(ref_clk_in), .ce_n_in(ce_n_out), .cle_in(cle_out),
      .ale_in(ale_out), .we_n_in(we_n_out), .re_n_in(re_n_out), .dq_in(bus), .dq_out(mdq),
      .rb_low_out(rb_low));
   task automatic tally_and_finish();
      if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin bad_count++; tally_and_finish(); end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in); addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
      @(posedge ref_clk_in); wr_in <= 1'b0;
   endtask
   // read data appear in the cycle after the strobe and hold until the next read
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_in); addr_in <= a; rd_in <= 1'b1;
      @(posedge ref_clk_in); rd_in <= 1'b0;
      #1 v = rdata_out;
   endtask
   task automatic wait_stat(input int b, input logic val);
      int n;
      n = 0;
      rd(8'h14);
      while (v[b] !== val && n < 4000) begin rd(8'h14); n++; end
      chk(v[b], val);
   endtask
   task automatic load(input logic [23:0] row, input logic [31:0] op);
      wr(8'h08, {8'h00, row});
      wr(8'h0c, 32'h3);
      wr(8'h00, op);
      for (int i = 0; i < 3; i++) begin
         wait_stat(1, 1'b1);
         wr(8'h10, 32'h11 + i);
      end
      wait_stat(0, 1'b0);
      chk(mdl_u.loads, 3);
   endtask
   task automatic t_power();
      rd(8'h14);
      chk(v[4], 1'b0);
      wait_stat(4, 1'b1);
      chk(wp_n_out, 1'b1);
   endtask
   task automatic t_prog();
      wr(8'h04, 32'h0123);
      load(24'h000040, 32'h9);
      chk(mdl_u.conf_q, 8'h10);
      chk({mdl_u.adr_b[1], mdl_u.adr_b[0], mdl_u.adr_b[2]}, 24'h012340);
   endtask
   task automatic t_cprog();
      load(24'h000080, 32'h1);
      chk(mdl_u.conf_q, 8'h15);
      rd(8'h14);
      chk(v[5], 1'b1);
      wr(8'h08, 32'hc0);
      wr(8'h00, 32'h1);
      rd(8'h14);
      chk(v[3], 1'b1);
      wr(8'h14, 32'h0);
      load(24'h000081, 32'h11);
      chk(mdl_u.prog_c, 0);
      rd(8'h14);
      chk(v[5:3], 3'h2);
   endtask
   task automatic t_cread();
      wr(8'h04, 32'h12);
      wr(8'h08, 32'h100);
      wr(8'h00, 32'h2);
      wait_stat(6, 1'b1);
      chk({mdl_u.adr_b[1], mdl_u.adr_b[0]}, 16'h0);
      chk(mdl_u.cmd_q, 8'h31);
      for (int i = 0; i < 5; i++) begin
         wait_stat(2, 1'b1);
         rd(8'h10);
         if (i > 0) chk(v[7:0], 8'ha0 + i - 1);
      end
      wr(8'h00, 32'h4);
      rd(8'h14);
      chk(v[3], 1'b1);
      chk(mdl_u.cmd_q, 8'h31);
      wr(8'h14, 32'h0);
      wr(8'h00, 32'h3);
      wait_stat(6, 1'b0);
      wait_stat(0, 1'b0);
      chk(mdl_u.cmd_q, 8'h34);
      chk(mdl_u.rd_c, 0);
   endtask
   task automatic t_status();
      wr(8'h00, 32'h4);
      wait_stat(0, 1'b0);
      chk(v[15:8], 8'he0);
   endtask
   initial begin
      repeat (10) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      t_power();
      t_prog();
      t_cprog();
      t_cread();
      t_status();
      tally_and_finish();
   end
endmodule
`default_nettype wire
